// *** common/chopper_switch_pkg.sv ***
/*
 * Shared constants for the quiet-mode / current-mode chopper selection block.
 * Assumes a single 200 MHz chopper clock domain.
 */
package chopper_switch_pkg;

    // ------------------------------------------------------------
    // Widths and limits
    // ------------------------------------------------------------
    localparam int unsigned STEP_INTERVAL_W = 20;
    localparam int unsigned AMPL_W          = 8;
    localparam logic [7:0]  AMPL_MAX        = 8'hff;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SUM_RESET       = 8'h00;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    // Missed full steps before an open-load flag rises.
    localparam logic [2:0]  OL_FULLSTEPS    = 3'h4;
    // Chopper periods the host keeps the motor still on first enable.
    localparam int unsigned STANDSTILL_PERIODS = 128;

endpackage

// *** verilog/chopper_mode_velocity_switch.sv ***
/*
 * Velocity-threshold selection between voltage-mode quiet chopping and
 * current-mode chopping, with the quiet-mode amplitude regulator, its
 * open-load flags and the voltage amplitude sum.
 * Assumes step_i comes from a pin (synchronised here); all other inputs,
 * including the chopper-period and full-step ticks and the current sense
 * magnitudes, come from logic on ref_clk_i.
 */
`timescale 1ns/1ps

module chopper_mode_velocity_switch
    import chopper_switch_pkg::*;
#(
    parameter int unsigned TW = STEP_INTERVAL_W
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              clk_en_i,
    input  wire logic              step_i,
    input  wire logic              quiet_mode_enable_i,
    input  wire logic              autoscale_enable_i,
    input  wire logic [TW-1:0]     quiet_mode_velocity_threshold_i,
    input  wire logic [7:0]        reentry_amplitude_setting_i,
    input  wire logic              chopper_period_tick_i,
    input  wire logic              fullstep_tick_i,
    input  wire logic [7:0]        target_current_a_i,
    input  wire logic [7:0]        target_current_b_i,
    input  wire logic [7:0]        measured_current_a_i,
    input  wire logic [7:0]        measured_current_b_i,
    output logic                   current_mode_o,
    output logic [TW-1:0]          step_interval_o,
    output logic [7:0]             voltage_amplitude_sum_o,
    output logic [7:0]             drive_scale_a_o,
    output logic [7:0]             drive_scale_b_o,
    output logic                   open_load_coil_a_o,
    output logic                   open_load_coil_b_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [TW-1:0] sat_inc_t(input logic [TW-1:0] v);
        sat_inc_t = (&v) ? v : v + 1'b1;
    endfunction

    function automatic logic [2:0] sat_inc3(input logic [2:0] v);
        sat_inc3 = (&v) ? v : v + 3'h1;
    endfunction

    // Coil drive is the common sum weighted by the coil's target taken as a fraction of 256.
    function automatic logic [7:0] scale_by(input logic [7:0] sum, input logic [7:0] tgt);
        logic [15:0] prod;
        prod     = sum * tgt;
        scale_by = prod[15:8];
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic          sync1;
        logic          sync2;
        logic          step_prev;
        logic [TW-1:0] cnt;
        logic [TW-1:0] interval;
        logic          cur_mode;
        logic [7:0]    sum;
        logic          reached_a;
        logic          reached_b;
        logic [2:0]    miss_a;
        logic [2:0]    miss_b;
        logic          open_load_coil_a;
        logic          open_load_coil_b;
        logic [7:0]    drv_a;
        logic [7:0]    drv_b;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic step_edge;
    logic go_current;
    logic a_larger;
    logic [7:0] reg_meas;
    logic [7:0] reg_tgt;
    logic hit_a;
    logic hit_b;

    assign step_edge = s_q.sync2 & ~s_q.step_prev;
    // Zero threshold keeps quiet mode; otherwise shorter interval means faster.
    assign go_current = ~quiet_mode_enable_i |
                        ((quiet_mode_velocity_threshold_i != '0) &&
                         (s_q.interval < quiet_mode_velocity_threshold_i));
    assign a_larger = target_current_a_i >= target_current_b_i;
    assign reg_meas = a_larger ? measured_current_a_i : measured_current_b_i;
    assign reg_tgt  = a_larger ? target_current_a_i : target_current_b_i;
    assign hit_a    = s_q.reached_a | (measured_current_a_i >= target_current_a_i);
    assign hit_b    = s_q.reached_b | (measured_current_b_i >= target_current_b_i);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = step_i;
        s_d.sync2 = s_q.sync1;
        s_d.step_prev = s_q.sync2;

        // Interval saturates so a stopped motor reads as the slowest speed.
        if (step_edge) begin
            s_d.interval = sat_inc_t(s_q.cnt);
            s_d.cnt      = '0;
        end else begin
            s_d.cnt = sat_inc_t(s_q.cnt);
            if (&s_q.cnt) begin
                s_d.interval = s_q.cnt;
            end
        end

        s_d.cur_mode = go_current;

        if (go_current) begin
            // Sum stays frozen as the restart point for re-entry.
            s_d.open_load_coil_a = 1'b0;
            s_d.open_load_coil_b = 1'b0;
            s_d.miss_a = '0;
            s_d.miss_b = '0;
            s_d.reached_a = 1'b0;
            s_d.reached_b = 1'b0;
        end else if (s_q.cur_mode) begin
            // Resume from the stored value, capped by the re-entry setting; without autoscale, load the setting.
            if (!autoscale_enable_i || s_q.sum > reentry_amplitude_setting_i) begin
                s_d.sum = reentry_amplitude_setting_i;
            end
        end else begin
            if (!autoscale_enable_i) begin
                s_d.sum = reentry_amplitude_setting_i;
            end else if (chopper_period_tick_i) begin
                // Only the larger-target coil is measured and regulated.
                if (reg_meas < reg_tgt && s_q.sum != AMPL_MAX) begin
                    s_d.sum = s_q.sum + 8'h01;
                end else if (reg_meas > reg_tgt && s_q.sum != 8'h00) begin
                    s_d.sum = s_q.sum - 8'h01;
                end
            end
            if (fullstep_tick_i) begin
                // A coil that never reaches target counts up; a hit clears it.
                s_d.miss_a = hit_a ? 3'h0 : sat_inc3(s_q.miss_a);
                s_d.miss_b = hit_b ? 3'h0 : sat_inc3(s_q.miss_b);
                s_d.open_load_coil_a    = s_d.miss_a >= OL_FULLSTEPS;
                s_d.open_load_coil_b    = s_d.miss_b >= OL_FULLSTEPS;
                s_d.reached_a = 1'b0;
                s_d.reached_b = 1'b0;
            end else begin
                s_d.reached_a = hit_a;
                s_d.reached_b = hit_b;
            end
        end

        // Other coil follows the regulated one in proportion to target.
        s_d.drv_a = a_larger ? s_d.sum : scale_by(s_d.sum, target_current_a_i);
        s_d.drv_b = a_larger ? scale_by(s_d.sum, target_current_b_i) : s_d.sum;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q          <= '0;
            s_q.cur_mode <= 1'b1;
            s_q.sum      <= SUM_RESET;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pure status views; reading them changes nothing.
    assign current_mode_o          = s_q.cur_mode;
    assign step_interval_o         = s_q.interval;
    assign voltage_amplitude_sum_o = s_q.sum;
    assign drive_scale_a_o         = s_q.drv_a;
    assign drive_scale_b_o         = s_q.drv_b;
    assign open_load_coil_a_o      = s_q.open_load_coil_a;
    assign open_load_coil_b_o      = s_q.open_load_coil_b;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_frozen_pair;
        clk_en_i && current_mode_o ##1 current_mode_o;
    endsequence

    property p_thr_zero;
        clk_en_i && quiet_mode_enable_i && quiet_mode_velocity_threshold_i == '0 |=> !current_mode_o;
    endproperty
    a_thr_zero: assert property (p_thr_zero) else $error("zero threshold left quiet mode");

    property p_fast_current;
        clk_en_i && quiet_mode_velocity_threshold_i != '0 && step_interval_o < quiet_mode_velocity_threshold_i
        |=> current_mode_o;
    endproperty
    a_fast_current: assert property (p_fast_current) else $error("fast motion stayed in quiet mode");

    property p_slow_quiet;
        clk_en_i && quiet_mode_enable_i && step_interval_o >= quiet_mode_velocity_threshold_i |=> !current_mode_o;
    endproperty
    a_slow_quiet: assert property (p_slow_quiet) else $error("slow motion not in quiet mode");

    property p_hold_sum;
        s_frozen_pair |-> $stable(voltage_amplitude_sum_o);
    endproperty
    a_hold_sum: assert property (p_hold_sum) else $error("sum changed in current mode");

    property p_reentry;
        clk_en_i && current_mode_o && !go_current
        |=> voltage_amplitude_sum_o <= $past(reentry_amplitude_setting_i);
    endproperty
    a_reentry: assert property (p_reentry) else $error("re-entry amplitude above setting");

    property p_regulate_up;
        clk_en_i && !current_mode_o && !go_current && autoscale_enable_i && chopper_period_tick_i &&
        reg_meas < reg_tgt && voltage_amplitude_sum_o != AMPL_MAX
        |=> voltage_amplitude_sum_o == $past(voltage_amplitude_sum_o) + 8'h01;
    endproperty
    a_regulate_up: assert property (p_regulate_up) else $error("regulator did not raise sum");

    property p_saturate;
        clk_en_i && voltage_amplitude_sum_o == AMPL_MAX && !current_mode_o && !go_current &&
        autoscale_enable_i && reg_meas < reg_tgt |=> voltage_amplitude_sum_o == AMPL_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("sum left limit while short of target");

    property p_ol_quiet_only;
        current_mode_o |-> !open_load_coil_a_o && !open_load_coil_b_o;
    endproperty
    a_ol_quiet_only: assert property (p_ol_quiet_only) else $error("open-load flag in current mode");

    property p_ol_persist;
        clk_en_i && open_load_coil_a_o && fullstep_tick_i && !hit_a && !current_mode_o && !go_current
        |=> open_load_coil_a_o;
    endproperty
    a_ol_persist: assert property (p_ol_persist) else $error("open-load flag dropped on missed step");

    property p_interval;
        clk_en_i && step_edge |=> step_interval_o == sat_inc_t($past(s_q.cnt));
    endproperty
    a_interval: assert property (p_interval) else $error("step interval mismatch");

endmodule // chopper_mode_velocity_switch

// *** testbench/coil_model.sv ***
/*
 * Two-coil motor model: each coil's sensed current follows its drive scale.
 * Assumes drive scales come from the switch block on ref_clk_i.
 */
`timescale 1ns/1ps
module coil_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       slow_i,
    input  wire logic       open_a_i,
    input  wire logic       open_b_i,
    input  wire logic [7:0] drive_a_i,
    input  wire logic [7:0] drive_b_i,
    output logic      [7:0] meas_a_o,
    output logic      [7:0] meas_b_o
);
    logic ph_q;
    // An open coil carries no current, so its sense reads zero.
    // The slow setting lags the sense to stress the regulator.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph_q     <= 1'b0;
            meas_a_o <= 8'h00;
            meas_b_o <= 8'h00;
        end else begin
            ph_q <= ~ph_q;
            if (!slow_i || ph_q) begin
                meas_a_o <= open_a_i ? 8'h00 : drive_a_i;
                meas_b_o <= open_b_i ? 8'h00 : drive_b_i;
            end
        end
    end
endmodule // coil_model

// *** testbench/tb_chopper_mode_velocity_switch.sv ***
/*
 * Self-checking bench for chopper_mode_velocity_switch driving a coil model.
 * Assumes a 200 MHz clock; expected values are queued and checked by a monitor.
 */
`timescale 1ns/1ps
module tb_chopper_mode_velocity_switch;
    import chopper_switch_pkg::*;
    typedef struct { int sel; logic [19:0] val; } note_t;
    logic        ref_clk_i, rst_b_i, step_i, quiet_en, auto_en, chop_tick, fs_tick;
    logic        open_a, open_b, slow, tick_en, cur_mode, ol_a, ol_b, clk_en;
    logic [19:0] thr, step_int;
    logic [7:0]  reent, tgt_a, tgt_b, meas_a, meas_b, amp_sum, drv_a, drv_b;
    // Starts at zero so the tick counter never sees an unknown at time zero.
    logic [31:0] cyc_cnt = 32'h0;
    int          seed;
    int          gap, err_count, n_checks;
    note_t       notes[$];
    note_t       nt;
    event        check_ev;

    chopper_mode_velocity_switch i_chopper_mode_velocity_switch (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en), .step_i(step_i),
        .quiet_mode_enable_i(quiet_en), .autoscale_enable_i(auto_en),
        .quiet_mode_velocity_threshold_i(thr), .reentry_amplitude_setting_i(reent),
        .chopper_period_tick_i(chop_tick), .fullstep_tick_i(fs_tick),
        .target_current_a_i(tgt_a), .target_current_b_i(tgt_b),
        .measured_current_a_i(meas_a), .measured_current_b_i(meas_b),
        .current_mode_o(cur_mode), .step_interval_o(step_int),
        .voltage_amplitude_sum_o(amp_sum), .drive_scale_a_o(drv_a), .drive_scale_b_o(drv_b),
        .open_load_coil_a_o(ol_a), .open_load_coil_b_o(ol_b));
    coil_model i_coil_model (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .slow_i(slow), .open_a_i(open_a),
        .open_b_i(open_b), .drive_a_i(drv_a), .drive_b_i(drv_b), .meas_a_o(meas_a), .meas_b_o(meas_b));

    // ------------------------------------------------------------
    // Clock, ticks and step source
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(negedge ref_clk_i) begin
        cyc_cnt   <= cyc_cnt + 32'h1;
        chop_tick <= tick_en && (cyc_cnt[2:0] == 3'h0);
        fs_tick   <= (cyc_cnt[4:0] == 5'h0);
    end
    initial begin
        forever begin
            if (gap != 0) begin
                step_i = 1'b1;
                @(negedge ref_clk_i);
                step_i = 1'b0;
                repeat (gap - 1) @(negedge ref_clk_i);
            end else @(negedge ref_clk_i);
        end
    end

    // ------------------------------------------------------------
    // Scoreboard
    // ------------------------------------------------------------
    function automatic logic [19:0] observed(input int sel);
        case (sel)
            0: return {19'h0, cur_mode};
            1: return step_int;
            2: return {12'h0, amp_sum};
            3: return {12'h0, drv_a};
            4: return {12'h0, drv_b};
            5: return {19'h0, ol_a};
            default: return {19'h0, ol_b};
        endcase
    endfunction
    task automatic expect_val(input int sel, input logic [19:0] val);
        notes.push_back('{sel, val});
        -> check_ev;
    endtask
    initial begin
        forever begin
            @(check_ev);
            while (notes.size() > 0) begin
                nt = notes.pop_front();
                n_checks++;
                if (observed(nt.sel) !== nt.val) begin
                    err_count++;
                    $display("Error at %0t: output %0d is %h, expected %h", $time, nt.sel, observed(nt.sel), nt.val);
                end
            end
        end
    end
    task automatic test_done;
        $display("Checks made: %0d, mismatches: %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic wait_sum(input logic [7:0] v);
        int i;
        for (i = 0; i < 4000 && amp_sum !== v; i++) @(negedge ref_clk_i);
        if (amp_sum !== v) begin
            err_count++;
            $display("Error at %0t: amplitude sum did not settle", $time);
            test_done();
        end
    endtask
    initial begin
        #100000;
        err_count++;
        $display("Error at %0t: run did not finish", $time);
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h2444;
        {rst_b_i, step_i, quiet_en, auto_en, open_a, open_b, slow, tick_en} = 8'h00;
        {chop_tick, fs_tick, thr, reent, tgt_a, tgt_b} = '0;
        clk_en = 1'b1;
        gap = 0;
        err_count = 0;
        n_checks = 0;
        cyc(16);
        rst_b_i = 1'b1;
        expect_val(0, 20'h1);
        expect_val(2, {12'h0, SUM_RESET});
        tgt_a = 8'h64; tgt_b = 8'h32; tick_en = 1'b1;
        cyc(40);
        expect_val(5, 20'h0);
        expect_val(6, 20'h0);
        // Quiet mode is first switched on with the motor at rest, so the regulator can settle.
        quiet_en = 1'b1; auto_en = 1'b1;
        cyc(STANDSTILL_PERIODS * 8);
        gap = 20;
        cyc(120);
        expect_val(0, 20'h0);
        expect_val(1, 20'd20);
        wait_sum(tgt_a);
        expect_val(3, {12'h0, tgt_a});
        expect_val(4, (20'(tgt_a) * 20'(tgt_b)) >> 8);
        thr = 20'd30;
        cyc(80);
        expect_val(0, 20'h1);
        cyc(200);
        expect_val(2, {12'h0, tgt_a});
        tick_en = 1'b0; reent = 8'h3c; gap = 30;
        cyc(150);
        expect_val(0, 20'h0);
        expect_val(2, {12'h0, reent});
        // A low clock enable must hold the regulator although chopper ticks run.
        clk_en = 1'b0; gap = 0; tick_en = 1'b1;
        cyc(80);
        expect_val(2, {12'h0, reent});
        clk_en = 1'b1;
        wait_sum(tgt_a);
        gap = 20;
        cyc(100);
        auto_en = 1'b0; reent = 8'($random(seed)); gap = 60;
        cyc(300);
        expect_val(0, 20'h0);
        expect_val(2, {12'h0, reent});
        auto_en = 1'b1; slow = 1'b1; tgt_a = 8'h32; tgt_b = 8'h64; open_b = 1'b1;
        reent = AMPL_MAX;
        wait_sum(AMPL_MAX);
        // The sum may start near its limit, so give the flags five full steps to rise.
        cyc(160);
        expect_val(6, 20'h1);
        expect_val(5, 20'h1);
        cyc(160);
        expect_val(6, 20'h1);
        gap = 20;
        cyc(100);
        expect_val(5, 20'h0);
        expect_val(6, 20'h0);
        open_b = 1'b0; gap = 0;
        cyc(5);
        test_done();
    end
endmodule // tb_chopper_mode_velocity_switch
